//--- core/spu_uart_regs.sv
/*
 * spu_uart_regs: apb register block and 8n1 bit engine of a spare
 * single-pin uart, with sticky events, mask and one interrupt line.
 * assumes an external pull-up on the shared pin and a clock-ready level
 * from the fast clock source; the bit engine counts pclk cycles.
 */
`timescale 1ns/10ps
module spu_uart_regs #(
    parameter logic [31:0] VERSION_VAL = spu_pkg::VERSION_RST
) (
    // clock and reset
    input  logic        pclk,
    input  logic        presetn,
    // apb slave
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [7:0]  paddr,
    input  logic [31:0] pwdata,
    output logic        pready,
    output logic [31:0] prdata,
    output logic        pslverr,
    // interrupt
    output logic        irq,
    // shared serial pin, open drain
    input  logic        line_in,
    output logic        line_out,
    output logic        line_oe,
    // fast clock control
    output logic        fast_clk_req,
    input  logic        fast_clk_ok
);

    // ========================================
    // state
    logic                   pready_q;
    logic [31:0]            prdata_q;
    logic                   pslverr_q;
    spu_pkg::spu_mode_t     mode_q;
    logic [15:0]            div_q;
    logic [7:0]             tx_byte_q;
    logic                   clk_req_q;
    logic                   synced_q;
    logic                   busy_q;
    logic                   busy_d;
    logic [2:0]             busy_cnt_q;
    spu_pkg::spu_ev_t       stat_q;
    spu_pkg::spu_ev_t       pend_q;
    spu_pkg::spu_ev_t       mask_q;
    spu_pkg::spu_ev_t       ev_set;
    spu_pkg::spu_ev_t       ev_clr;
    logic                   irq_q;
    logic [7:0]             rx_byte_q;
    logic                   unread_q;
    logic                   ln1_q;
    logic                   ln2_q;
    logic                   ln3_q;
    logic                   con1_q;
    logic                   con2_q;
    spu_pkg::spu_tx_st_t    tx_st_q;
    logic [15:0]            tx_cnt_q;
    logic [2:0]             tx_idx_q;
    logic [7:0]             tx_sh_q;
    logic                   oe_q;
    spu_pkg::spu_rx_st_t    rx_st_q;
    logic [15:0]            rx_cnt_q;
    logic [2:0]             rx_idx_q;
    logic [7:0]             rx_sh_q;
    logic [31:0]            rdata;
    logic                   mapped;

    // ========================================
    // decode
    logic        setup_acc;
    logic        xfer;
    logic        wr_en;
    logic        cfg_sel;
    logic        cfg_wr;
    logic        ctrl_wr;
    logic        rx_read;
    logic [15:0] period;
    logic [15:0] half;
    logic        rx_en;
    logic        fall;
    logic        rx_store;
    logic        sync_hit;
    logic        tx_collide;

    assign setup_acc = psel & penable & ~pready_q;
    assign xfer      = psel & penable & pready_q;
    assign wr_en     = xfer & pwrite;
    assign cfg_sel   = (paddr == spu_pkg::OFS_CTRL) | (paddr == spu_pkg::OFS_DIV)
                     | (paddr == spu_pkg::OFS_TX);
    assign cfg_wr    = wr_en & cfg_sel & ~busy_q;
    assign ctrl_wr   = cfg_wr & (paddr == spu_pkg::OFS_CTRL);
    assign rx_read   = xfer & ~pwrite & (paddr == spu_pkg::OFS_RX);
    assign period    = spu_pkg::bit_cyc(div_q);
    assign half      = period >> 1;
    assign rx_en     = (mode_q == spu_pkg::MODE_RX) | (mode_q == spu_pkg::MODE_RESYNC);
    assign fall      = ln3_q & ~ln2_q;
    assign rx_store  = (rx_st_q == spu_pkg::RX_STOP) & (rx_cnt_q == 16'h0000);
    assign sync_hit  = (rx_st_q == spu_pkg::RX_SYNC) & fall & (rx_idx_q == spu_pkg::SYNC_EDGES);
    assign tx_collide = ((tx_st_q == spu_pkg::TX_DATA) | (tx_st_q == spu_pkg::TX_STOP))
                      & ~oe_q & ~ln2_q & (tx_cnt_q == half);

    // ========================================
    // outputs
    assign pready       = pready_q;
    assign prdata       = prdata_q;
    assign pslverr      = pslverr_q;
    assign irq          = irq_q;
    assign line_out     = 1'b0;
    assign line_oe      = oe_q;
    assign fast_clk_req = clk_req_q;

    // ========================================
    // read mux
    always_comb begin
        rdata  = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            spu_pkg::OFS_CTRL:    rdata[1:0] = mode_q;
            spu_pkg::OFS_STATUS: begin
                rdata = spu_pkg::ev_to_word(stat_q);
                rdata[spu_pkg::CLKON_BIT] = con2_q;
                rdata[spu_pkg::BUSY_BIT]  = busy_q;
            end
            spu_pkg::OFS_CLEAR:   rdata = 32'h0000_0000;
            spu_pkg::OFS_IEN_SET: rdata = 32'h0000_0000;
            spu_pkg::OFS_IEN_CLR: rdata = 32'h0000_0000;
            spu_pkg::OFS_MASK:    rdata = spu_pkg::ev_to_word(mask_q);
            spu_pkg::OFS_RX:      rdata[7:0] = rx_byte_q;
            spu_pkg::OFS_TX:      rdata[7:0] = tx_byte_q;
            spu_pkg::OFS_DIV:     rdata[15:0] = div_q;
            spu_pkg::OFS_VER:     rdata = VERSION_VAL;
            spu_pkg::OFS_CLKREQ:  rdata[spu_pkg::FAST_CLOCK_REQUEST_BIT_BIT] = clk_req_q;
            default:              mapped = 1'b0;
        endcase
    end

    // ========================================
    // apb handshake, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup_acc;
            if (setup_acc) begin
                prdata_q  <= pwrite ? 32'h0000_0000 : rdata;
                pslverr_q <= ~mapped;
            end
        end
    end

    // ========================================
    // configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q    <= spu_pkg::MODE_OFF;
            div_q     <= spu_pkg::RST_DIV;
            tx_byte_q <= spu_pkg::RST_BYTE;
            clk_req_q <= 1'b0;
            synced_q  <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                mode_q   <= spu_pkg::spu_mode_t'(pwdata[1:0]);
                synced_q <= 1'b0;
            end
            if (cfg_wr && paddr == spu_pkg::OFS_DIV) begin
                div_q <= pwdata[15:0];
            end else if (sync_hit) begin
                div_q    <= rx_cnt_q + 16'h0001;
                synced_q <= 1'b1;
            end
            if (cfg_wr && paddr == spu_pkg::OFS_TX) begin
                tx_byte_q <= pwdata[7:0];
            end
            if (wr_en && paddr == spu_pkg::OFS_CLKREQ) begin
                clk_req_q <= pwdata[spu_pkg::FAST_CLOCK_REQUEST_BIT_BIT];
            end
        end
    end

    // ========================================
    // pin and clock-ready synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ln1_q  <= 1'b1;
            ln2_q  <= 1'b1;
            ln3_q  <= 1'b1;
            con1_q <= 1'b0;
            con2_q <= 1'b0;
        end else begin
            ln1_q  <= line_in;
            ln2_q  <= ln1_q;
            ln3_q  <= ln2_q;
            con1_q <= fast_clk_ok;
            con2_q <= con1_q;
        end
    end

    // ========================================
    // busy: crossing delay, then frame in flight
    always_comb begin
        busy_d = cfg_wr | (busy_cnt_q != 3'h0) | (tx_st_q != spu_pkg::TX_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q     <= 1'b0;
            busy_cnt_q <= 3'h0;
        end else begin
            busy_q <= busy_d;
            if (cfg_wr) begin
                busy_cnt_q <= spu_pkg::SYNC_CYCLES;
            end else if (busy_cnt_q != 3'h0) begin
                busy_cnt_q <= busy_cnt_q - 3'h1;
            end
        end
    end

    // ========================================
    // events, mask and interrupt
    always_comb begin
        ev_set.collide = tx_collide;
        ev_set.lost    = rx_store & unread_q & ~rx_read;
        ev_set.avail   = rx_store;
        ev_set.done    = busy_q & ~busy_d;
        ev_clr = (wr_en && paddr == spu_pkg::OFS_CLEAR) ? spu_pkg::word_to_ev(pwdata)
                                                       : spu_pkg::spu_ev_t'(4'h0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= spu_pkg::spu_ev_t'(4'h0);
            pend_q <= spu_pkg::spu_ev_t'(4'h0);
            irq_q  <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~ev_clr) | ev_set;
            pend_q <= (pend_q & ~ev_clr) | (ev_set & ~stat_q & mask_q);
            irq_q  <= |(pend_q & mask_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= spu_pkg::spu_ev_t'(4'h0);
        end else if (wr_en && paddr == spu_pkg::OFS_IEN_SET) begin
            mask_q <= mask_q | spu_pkg::word_to_ev(pwdata);
        end else if (wr_en && paddr == spu_pkg::OFS_IEN_CLR) begin
            mask_q <= mask_q & ~spu_pkg::word_to_ev(pwdata);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_byte_q <= spu_pkg::RST_BYTE;
            unread_q  <= 1'b0;
        end else if (rx_store) begin
            rx_byte_q <= rx_sh_q;
            unread_q  <= 1'b1;
        end else if (rx_read) begin
            unread_q  <= 1'b0;
        end
    end

    // ========================================
    // transmitter, drives the pin low for zeros
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_q  <= spu_pkg::TX_IDLE;
            tx_cnt_q <= 16'h0000;
            tx_idx_q <= 3'h0;
            tx_sh_q  <= 8'h00;
            oe_q     <= 1'b0;
        end else if (mode_q != spu_pkg::MODE_TX) begin
            tx_st_q <= spu_pkg::TX_IDLE;
            oe_q    <= 1'b0;
        end else begin
            case (tx_st_q)
                spu_pkg::TX_IDLE: begin
                    if (cfg_wr && paddr == spu_pkg::OFS_TX) begin
                        tx_sh_q  <= pwdata[7:0];
                        tx_cnt_q <= period - 16'h0001;
                        oe_q     <= 1'b1;
                        tx_st_q  <= spu_pkg::TX_START;
                    end
                end
                spu_pkg::TX_START: begin
                    if (tx_cnt_q == 16'h0000) begin
                        tx_cnt_q <= period - 16'h0001;
                        tx_idx_q <= 3'h0;
                        oe_q     <= ~tx_sh_q[0];
                        tx_st_q  <= spu_pkg::TX_DATA;
                    end else begin
                        tx_cnt_q <= tx_cnt_q - 16'h0001;
                    end
                end
                spu_pkg::TX_DATA: begin
                    if (tx_cnt_q == 16'h0000) begin
                        tx_cnt_q <= period - 16'h0001;
                        if (tx_idx_q == 3'h7) begin
                            oe_q    <= 1'b0;
                            tx_st_q <= spu_pkg::TX_STOP;
                        end else begin
                            tx_idx_q <= tx_idx_q + 3'h1;
                            tx_sh_q  <= tx_sh_q >> 1;
                            oe_q     <= ~tx_sh_q[1];
                        end
                    end else begin
                        tx_cnt_q <= tx_cnt_q - 16'h0001;
                    end
                end
                spu_pkg::TX_STOP: begin
                    if (tx_cnt_q == 16'h0000) begin
                        tx_st_q <= spu_pkg::TX_IDLE;
                    end else begin
                        tx_cnt_q <= tx_cnt_q - 16'h0001;
                    end
                end
                default: tx_st_q <= spu_pkg::TX_IDLE;
            endcase
        end
    end

    // ========================================
    // receiver and 0x55 rate capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_q  <= spu_pkg::RX_IDLE;
            rx_cnt_q <= 16'h0000;
            rx_idx_q <= 3'h0;
            rx_sh_q  <= 8'h00;
        end else if (!rx_en || ctrl_wr) begin
            rx_st_q <= spu_pkg::RX_IDLE;
        end else begin
            case (rx_st_q)
                spu_pkg::RX_IDLE: begin
                    rx_idx_q <= 3'h0;
                    if (fall && mode_q == spu_pkg::MODE_RESYNC && !synced_q) begin
                        rx_cnt_q <= 16'h0000;
                        rx_st_q  <= spu_pkg::RX_SYNC;
                    end else if (fall) begin
                        rx_cnt_q <= half;
                        rx_st_q  <= spu_pkg::RX_START;
                    end
                end
                spu_pkg::RX_START: begin
                    if (rx_cnt_q != 16'h0000) begin
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                    end else if (!ln2_q) begin
                        rx_cnt_q <= period - 16'h0001;
                        rx_st_q  <= spu_pkg::RX_DATA;
                    end else begin
                        rx_st_q <= spu_pkg::RX_IDLE;
                    end
                end
                spu_pkg::RX_DATA: begin
                    if (rx_cnt_q == 16'h0000) begin
                        rx_sh_q  <= {ln2_q, rx_sh_q[7:1]};
                        rx_cnt_q <= period - 16'h0001;
                        rx_idx_q <= rx_idx_q + 3'h1;
                        if (rx_idx_q == 3'h7) begin
                            rx_st_q <= spu_pkg::RX_STOP;
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                    end
                end
                spu_pkg::RX_STOP: begin
                    if (rx_cnt_q == 16'h0000) begin
                        rx_st_q <= spu_pkg::RX_IDLE;
                    end else begin
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                    end
                end
                spu_pkg::RX_SYNC: begin
                    rx_cnt_q <= rx_cnt_q + 16'h0001;
                    if (sync_hit) begin
                        rx_st_q <= spu_pkg::RX_IDLE;
                    end else if (fall) begin
                        rx_idx_q <= rx_idx_q + 3'h1;
                    end
                end
                default: rx_st_q <= spu_pkg::RX_IDLE;
            endcase
        end
    end

    // ========================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cfg_write;
        cfg_wr && !(paddr == spu_pkg::OFS_TX && mode_q == spu_pkg::MODE_TX);
    endsequence

    a_busy_blocks_ctrl: assert property (
        busy_q && wr_en && paddr == spu_pkg::OFS_CTRL |=> mode_q == $past(mode_q))
        else $error("control changed while busy");

    a_busy_span: assert property (
        s_cfg_write |=> busy_q [*5] ##1 !busy_q)
        else $error("busy span wrong after config write");

    a_done_on_fall: assert property (
        $fell(busy_q) |-> stat_q.done)
        else $error("done flag missing at busy fall");

    a_avail_store: assert property (
        rx_store |=> stat_q.avail && unread_q)
        else $error("available flag missing after store");

    a_lost_store: assert property (
        rx_store && unread_q && !rx_read |=> stat_q.lost)
        else $error("lost flag missing on overwrite");

    a_clear_avail: assert property (
        wr_en && paddr == spu_pkg::OFS_CLEAR && pwdata[9] && !rx_store
        |=> !stat_q.avail && !pend_q.avail)
        else $error("clear did not drop available flag");

    a_mask_set: assert property (
        wr_en && paddr == spu_pkg::OFS_IEN_SET && pwdata[13] |=> mask_q.collide)
        else $error("mask bit not set");

    a_mask_clear: assert property (
        wr_en && paddr == spu_pkg::OFS_IEN_CLR && pwdata[8] |=> !mask_q.done)
        else $error("mask bit not cleared");

    a_rx_upper: assert property (
        setup_acc && !pwrite && paddr == spu_pkg::OFS_RX |=> prdata_q[31:8] == 24'h00_0000)
        else $error("rx byte upper bits not zero");

    a_collide_flag: assert property (
        tx_collide |=> stat_q.collide)
        else $error("collision flag missing");

    a_irq_masked: assert property (
        irq_q |-> $past(stat_q) != 4'h0)
        else $error("interrupt without a set flag");

    a_sync_div: assert property (
        sync_hit && !cfg_wr |=> div_q == $past(rx_cnt_q) + 16'h0001 && synced_q)
        else $error("divisor not captured from sync byte");

endmodule

//--- core/spu_pkg.sv
/*
 * spu_pkg: offsets, field positions, reset values, types and helpers of the
 * single-pin uart user registers.
 * assumes a 32-bit apb slave with byte addresses on paddr.
 */
package spu_pkg;

    // ========================================
    // register offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_CLEAR   = 8'h08;
    localparam logic [7:0] OFS_IEN_SET = 8'h0c;
    localparam logic [7:0] OFS_IEN_CLR = 8'h10;
    localparam logic [7:0] OFS_MASK    = 8'h14;
    localparam logic [7:0] OFS_RX      = 8'h18;
    localparam logic [7:0] OFS_TX      = 8'h1c;
    localparam logic [7:0] OFS_DIV     = 8'h20;
    localparam logic [7:0] OFS_VER     = 8'h24;
    localparam logic [7:0] OFS_CLKREQ  = 8'h28;

    // ========================================
    // field positions
    localparam int EV_COLLIDE_BIT = 13;
    localparam int EV_LOST_BIT    = 10;
    localparam int EV_AVAIL_BIT   = 9;
    localparam int EV_DONE_BIT    = 8;
    localparam int CLKON_BIT      = 2;
    localparam int BUSY_BIT       = 0;
    localparam int FAST_CLOCK_REQUEST_BIT_BIT      = 0;

    // ========================================
    // reset values and counts
    localparam logic [15:0] RST_DIV     = 16'h0000;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [31:0] VERSION_RST = 32'h0000_0a5a; // arbitrary value
    localparam logic [2:0]  SYNC_CYCLES = 3'h4;
    localparam logic [2:0]  SYNC_EDGES  = 3'h3;

    // ========================================
    // types
    typedef enum logic [1:0] {
        MODE_OFF    = 2'h0,
        MODE_RX     = 2'h1,
        MODE_TX     = 2'h2,
        MODE_RESYNC = 2'h3
    } spu_mode_t;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'h0,
        TX_START = 2'h1,
        TX_DATA  = 2'h3,
        TX_STOP  = 2'h2
    } spu_tx_st_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'h0,
        RX_START = 3'h1,
        RX_DATA  = 3'h3,
        RX_STOP  = 3'h2,
        RX_SYNC  = 3'h6
    } spu_rx_st_t;

    typedef struct packed {
        logic collide;
        logic lost;
        logic avail;
        logic done;
    } spu_ev_t;

    // ========================================
    // helpers
    function automatic logic [31:0] ev_to_word(input spu_ev_t e);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[EV_COLLIDE_BIT] = e.collide;
        w[EV_LOST_BIT]    = e.lost;
        w[EV_AVAIL_BIT]   = e.avail;
        w[EV_DONE_BIT]    = e.done;
        return w;
    endfunction

    function automatic spu_ev_t word_to_ev(input logic [31:0] w);
        spu_ev_t e;
        e.collide = w[EV_COLLIDE_BIT];
        e.lost    = w[EV_LOST_BIT];
        e.avail   = w[EV_AVAIL_BIT];
        e.done    = w[EV_DONE_BIT];
        return e;
    endfunction

    function automatic logic [15:0] bit_cyc(input logic [15:0] div);
        logic [15:0] c;
        c = div >> 3;
        return (c == 16'h0000) ? 16'h0001 : c;
    endfunction

endpackage

//--- verif/spu_peer.sv
/*
 * spu_peer: remote 8n1 serial peer on the shared open-drain pin.
 * assumes a pull-up on the line; bit time is given in pclk cycles.
 */
`timescale 1ns/10ps
module spu_peer (
    // clock and pin
    input  wire logic pclk,
    input  wire logic line,
    output logic      pull_low
);
    initial pull_low = 1'b0;
    // ========================================
    // frames
    task automatic send(input logic [7:0] b, input int cyc);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk) pull_low <= ~f[i];
            repeat (cyc - 1) @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
    endtask
    task automatic recv(output logic [7:0] b, input int cyc);
        int n;
        n = 0;
        while (line !== 1'b0 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 400) begin
            tb.mismatches++;
            tb.wrap_up();
        end
        repeat (cyc / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (cyc) @(posedge pclk);
            b[i] = line;
        end
    endtask
    task automatic jam(input int n);
        @(posedge pclk) pull_low <= 1'b1;
        repeat (n) @(posedge pclk);
        pull_low <= 1'b0;
    endtask
endmodule

//--- verif/tb.sv
/*
 * tb: self-checking bench of spu_uart_regs over apb with a serial peer.
 * assumes one wait state per apb access and the package constants.
 */
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, e, s); end end
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic        line_out, line_oe, fast_clk_req, fast_clk_ok, pull_low;
    logic [7:0]  paddr, b;
    logic [31:0] pwdata, prdata, rd, seed, r;
    int          mismatches, n_compared;
    wire logic   line = ~(line_oe | pull_low);
    spu_uart_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq), .line_in(line), .line_out(line_out),
        .line_oe(line_oe), .fast_clk_req(fast_clk_req), .fast_clk_ok(fast_clk_ok));
    spu_peer peer (.pclk(pclk), .line(line), .pull_low(pull_low));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) fast_clk_ok <= fast_clk_req;
    // ========================================
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin mismatches++; wrap_up(); end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input int bitn, input logic v);
        int n;
        n = 0;
        do begin apb(0, spu_pkg::OFS_STATUS, 0); n++; end while (rd[bitn] !== v && n < 300);
        if (n >= 300) begin mismatches++; wrap_up(); end
    endtask
    initial begin
        #900000;
        mismatches++;
        wrap_up();
    end
    // ========================================
    // scenarios
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fast_clk_ok, presetn} = '0;
        seed = 32'h2323_4f24;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            apb(0, 8'(i * 4), 0);
            `CHK("reset", (i == 9) ? spu_pkg::VERSION_RST : 32'h0000_0000, rd)
            `CHK("slverr", (i == 11), er)
        end
        `CHK("line out", 1'b0, line_out)
        $display("end reset");
        apb(1, spu_pkg::OFS_CLKREQ, 1);
        poll(spu_pkg::CLKON_BIT, 1);
        `CHK("clock on", 32'h0000_0004, rd)
        r = xs();
        apb(1, spu_pkg::OFS_IEN_SET, 32'hffff_ffff);
        apb(1, spu_pkg::OFS_IEN_CLR, r);
        apb(0, spu_pkg::OFS_MASK, 0);
        `CHK("mask", 32'h0000_2700 & ~r, rd)
        apb(1, spu_pkg::OFS_IEN_SET, 32'h0000_2700);
        $display("end mask");
        for (int m = 0; m < 4; m++) begin
            apb(1, spu_pkg::OFS_CLEAR, 32'h0000_2700);
            apb(1, spu_pkg::OFS_CTRL, m);
            apb(1, spu_pkg::OFS_DIV, xs());
            poll(spu_pkg::BUSY_BIT, 0);
            apb(0, spu_pkg::OFS_CTRL, 0);
            `CHK("mode", 32'(m), rd)
            apb(0, spu_pkg::OFS_DIV, 0);
            `CHK("blocked", 32'h0000_0000, rd)
            apb(0, spu_pkg::OFS_STATUS, 0);
            `CHK("done", 32'h0000_0104, rd)
            `CHK("irq done", 1'b1, irq)
        end
        apb(1, spu_pkg::OFS_CLEAR, 32'h0000_2700);
        apb(0, spu_pkg::OFS_STATUS, 0);
        `CHK("cleared", 32'h0000_0004, rd)
        `CHK("irq off", 1'b0, irq)
        $display("end modes");
        apb(1, spu_pkg::OFS_CTRL, 1);
        poll(spu_pkg::BUSY_BIT, 0);
        apb(1, spu_pkg::OFS_DIV, 32);
        poll(spu_pkg::BUSY_BIT, 0);
        apb(1, spu_pkg::OFS_CLEAR, 32'h0000_2700);
        r = xs();
        peer.send(r[31:24], 4);
        peer.send(r[7:0], 4);
        poll(spu_pkg::EV_LOST_BIT, 1);
        `CHK("rx events", 32'h0000_0604, rd)
        `CHK("irq rx", 1'b1, irq)
        apb(0, spu_pkg::OFS_RX, 0);
        `CHK("rx byte", {24'h00_0000, r[7:0]}, rd)
        $display("end receive");
        apb(1, spu_pkg::OFS_CTRL, 3);
        poll(spu_pkg::BUSY_BIT, 0);
        apb(1, spu_pkg::OFS_CLEAR, 32'h0000_2700);
        peer.send(8'h55, 5);
        peer.send(r[15:8], 5);
        poll(spu_pkg::EV_AVAIL_BIT, 1);
        apb(0, spu_pkg::OFS_RX, 0);
        `CHK("resync byte", {24'h00_0000, r[15:8]}, rd)
        apb(0, spu_pkg::OFS_DIV, 0);
        `CHK("resync div", 32'h0000_0028, rd)
        $display("end resync");
        apb(1, spu_pkg::OFS_CTRL, 2);
        poll(spu_pkg::BUSY_BIT, 0);
        fork
            peer.recv(b, 5);
            apb(1, spu_pkg::OFS_TX, r[23:16]);
        join
        `CHK("tx byte", r[23:16], b)
        poll(spu_pkg::BUSY_BIT, 0);
        apb(1, spu_pkg::OFS_CLEAR, 32'hffff_ffff);
        apb(1, spu_pkg::OFS_TX, 32'h0000_00ff);
        peer.jam(12);
        poll(spu_pkg::BUSY_BIT, 0);
        apb(0, spu_pkg::OFS_STATUS, 0);
        `CHK("collision", 32'h0000_2104, rd)
        $display("end transmit");
        wrap_up();
    end
endmodule
